// ==== acp_params.svh ====
/*
 audio crosspoint and channel processor: offsets, field positions, reset values, levels.
 assumes 24-bit signed audio samples, 48 kHz sample strobe, APB with byte addresses.
*/
// Summary of operation
// RULE1: crosspoint has ten sources and eight outputs; sources 0-7 are de-embedded channels
// RULE2: source 8 is the internal 1 kHz sine, source 9 is silence
// RULE3: per-group embedding enable, 0 disables and 1 enables embedding
// RULE4: sine level accepts only -180 or -200 cBFS, other values rejected
// RULE5: the sine at the configured level is a fallback source for change-over
// RULE6: one processing unit per change-over output toward the embedder
// RULE7: normal passes left and right straight, swap exchanges them
// RULE8: left duplicate copies left to both, right duplicate copies right to both
// RULE9: left invert or right invert flips one channel, other passes unchanged
// RULE10: mono drives both outputs with (l+r)/2
// RULE11: sum/difference drives (l+r)/2 first and (l-r)/2 second
// RULE12: each unit applies its own gain regardless of mode
// RULE13: change-over picks crosspoint, sine, silence or mute by priority codes 0-3
// RULE14: routing and mode changes take effect only on a sample boundary
// RULE15: mono, difference and gain results saturate instead of wrapping
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH
`define ACP_ROUTE 8'h00
`define ACP_EMB 8'h04
`define ACP_LVL 8'h08
`define ACP_FB 8'h0c
`define ACP_MODE 8'h10
`define ACP_STAT 8'h14
`define ACP_GAIN_BASE 3'h1
`define ACP_ROUTE_RST 32'h76543210
`define ACP_GAIN_UNITY 16'h2000
`define ACP_GAIN_SHIFT 13
`define ACP_LVL_HI -32'sd180
`define ACP_LVL_LO -32'sd200
`define ACP_AMP_HI 21'h101d24
`define ACP_AMP_LO 21'h0cccce
`define ACP_SRC_SINE 4'h8
`define ACP_SRC_MAX 4'h9
`define ACP_PH_LAST 6'h2f
`define ACP_PH_HALF 6'h18
`define ACP_PH_QTR 6'h0c
`endif

// ==== acp_pkg.sv ====
/*
 audio crosspoint processor types: modes, fallback codes, block state.
 assumes nothing beyond the params header.
*/
package acp_pkg;
   typedef enum logic [2:0] {
      normal_mode = 3'h0, swap_mode = 3'h1, left_duplicate_mode = 3'h2,
      right_duplicate_mode = 3'h3, left_invert_mode = 3'h4, right_invert_mode = 3'h5,
      mono_mode = 3'h6, sum_difference_mode = 3'h7
   } acp_mode_t;
   typedef enum logic [1:0] {
      fb_xpt = 2'h0, fb_sine = 2'h1, fb_silence = 2'h2, fb_mute = 2'h3
   } acp_fb_t;
   typedef struct packed {
      logic [31:0] route;
      logic [1:0] emb;
      logic lvl;
      logic [15:0] fb;
      logic [15:0] alt;
      logic [23:0] mode;
      logic [127:0] gain;
      logic [5:0] ph;
      logic [191:0] dout;
      logic [7:0] vout;
      logic stb;
      logic [31:0] rdata;
      logic err;
   } acp_state_t;
endpackage : acp_pkg

// ==== acp_core.sv ====
/*
 audio crosspoint, sine source, change-over fallback and per-channel processing.
 assumes smp_stb pulses one cycle per sample with de_data/de_valid stable in that cycle.
*/
// Decided for this implementation: the APB slave port and the placing of the registers.
`include "acp_params.svh"
`timescale 1ns/100ps
`default_nettype none
module acp_core (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic smp_stb,
   input wire logic [191:0] de_data,
   input wire logic [7:0] de_valid,
   output logic [191:0] out_data,
   output logic [7:0] out_valid,
   output logic out_stb,
   output logic [1:0] emb_en
);
   import acp_pkg::*;

   acp_state_t s_q, s_d;

   // clamp a wide signed value to 24-bit full scale
   function automatic logic [23:0] sat24(input logic signed [40:0] v);
      if (v > 41'sd8388607) sat24 = 24'h7fffff;
      else if (v < -41'sd8388608) sat24 = 24'h800000;
      else sat24 = v[23:0];
   endfunction : sat24

   // quarter-wave sine, 48 steps per cycle gives 1 kHz at 48 kHz
   function automatic logic [23:0] sine_val(input logic [5:0] ph, input logic hi);
      logic [5:0] q;
      logic [15:0] t;
      logic [36:0] p;
      logic [23:0] mag;
      q = (ph >= `ACP_PH_HALF) ? ph - `ACP_PH_HALF : ph;
      if (q > `ACP_PH_QTR) q = `ACP_PH_HALF - q;
      case (q)
         6'h00: t = 16'h0000;
         6'h01: t = 16'h10b5;
         6'h02: t = 16'h2121;
         6'h03: t = 16'h30fc;
         6'h04: t = 16'h4000;
         6'h05: t = 16'h4dec;
         6'h06: t = 16'h5a82;
         6'h07: t = 16'h658d;
         6'h08: t = 16'h6eda;
         6'h09: t = 16'h7642;
         6'h0a: t = 16'h7ba3;
         6'h0b: t = 16'h7ee8;
         default: t = 16'h8000; // full-scale step, so the crest equals the set amplitude
      endcase
      p = {16'h0000, hi ? `ACP_AMP_HI : `ACP_AMP_LO} * {21'h000000, t};
      mag = 24'(p[36:15]);
      sine_val = (ph >= `ACP_PH_HALF) ? 24'h000000 - mag : mag;
   endfunction : sine_val

   // channel mode of one unit; odd units produce the second output
   function automatic logic signed [24:0] proc(input logic [2:0] m, input logic odd,
         input logic signed [23:0] l, input logic signed [23:0] r);
      case (acp_mode_t'(m))
         normal_mode: proc = odd ? 25'(r) : 25'(l); // RULE7
         swap_mode: proc = odd ? 25'(l) : 25'(r); // RULE7
         left_duplicate_mode: proc = 25'(l); // RULE8
         right_duplicate_mode: proc = 25'(r); // RULE8
         left_invert_mode: proc = odd ? 25'(r) : -25'(l); // RULE9
         right_invert_mode: proc = odd ? -25'(r) : 25'(l); // RULE9
         mono_mode: proc = (25'(l) + 25'(r)) >>> 1; // RULE10
         sum_difference_mode: proc = odd ? (25'(l) - 25'(r)) >>> 1
                                       : (25'(l) + 25'(r)) >>> 1; // RULE11
         default: proc = 25'(l);
      endcase
   endfunction : proc

   logic [191:0] co;
   logic [7:0] cv;
   logic [23:0] sine_s;
   logic wr;
   logic bad;
   logic signed [32:0] lv;

   // crosspoint, fallback, processing and register access
   always_comb begin
      logic [3:0] src;
      logic [1:0] code;
      logic signed [24:0] pv;
      logic signed [40:0] gv;
      logic [23:0] xd;
      logic xv;
      src = 4'h0;
      code = 2'h0;
      pv = 25'sd0;
      gv = 41'sd0;
      xd = 24'h000000;
      xv = 1'b0;
      s_d = s_q;
      s_d.stb = 1'b0;
      co = '0;
      cv = '0;
      sine_s = sine_val(s_q.ph, s_q.lvl); // RULE4
      for (int i = 0; i < 8; i++) begin
         src = s_q.route[i*4 +: 4];
         // source select: channels, sine, silence
         if (src < `ACP_SRC_SINE) begin // RULE1
            xd = de_data[src[2:0]*24 +: 24];
            xv = de_valid[src[2:0]];
         end else begin
            xd = (src == `ACP_SRC_SINE) ? sine_s : 24'h000000; // RULE2
            xv = 1'b1;
         end
         // a missing crosspoint input drops to the second priority
         code = s_q.fb[i*2 +: 2];
         if (code == fb_xpt && !xv) code = s_q.alt[i*2 +: 2]; // RULE13
         case (acp_fb_t'(code))
            fb_xpt: begin co[i*24 +: 24] = xd; cv[i] = xv; end
            fb_sine: begin co[i*24 +: 24] = sine_s; cv[i] = 1'b1; end // RULE5
            fb_silence: begin co[i*24 +: 24] = 24'h000000; cv[i] = 1'b1; end
            default: begin co[i*24 +: 24] = 24'h000000; cv[i] = 1'b0; end
         endcase
      end
      // only a strobe moves the outputs, so settings land on sample edges
      if (smp_stb) begin // RULE14
         for (int i = 0; i < 8; i++) begin // RULE6
            pv = proc(s_q.mode[i*3 +: 3], i[0], co[(i & 6)*24 +: 24], co[(i | 1)*24 +: 24]);
            gv = (41'(pv) * $signed({25'h0000000, s_q.gain[i*16 +: 16]}))
                 >>> `ACP_GAIN_SHIFT; // RULE12
            s_d.dout[i*24 +: 24] = sat24(gv); // RULE15
            s_d.vout[i] = cv[i] & s_q.emb[i/4]; // RULE3
         end
         s_d.ph = (s_q.ph == `ACP_PH_LAST) ? 6'h00 : s_q.ph + 6'h01;
         s_d.stb = 1'b1;
      end
      // value checks done in setup so the error is ready in access
      lv = $signed({pwdata[31], pwdata});
      bad = 1'b0;
      case (paddr)
         `ACP_ROUTE: for (int k = 0; k < 8; k++)
            if (pwrite && pwdata[k*4 +: 4] > `ACP_SRC_MAX) bad = 1'b1;
         `ACP_LVL: bad = pwrite && lv != `ACP_LVL_HI && lv != `ACP_LVL_LO; // RULE4
         `ACP_EMB, `ACP_FB, `ACP_MODE, `ACP_STAT: bad = 1'b0;
         default: bad = paddr[7:5] != `ACP_GAIN_BASE || paddr[1:0] != 2'h0;
      endcase
      if (psel && !penable) begin
         s_d.err = bad;
         case (paddr)
            `ACP_ROUTE: s_d.rdata = s_q.route;
            `ACP_EMB: s_d.rdata = {30'h0, s_q.emb};
            `ACP_LVL: s_d.rdata = s_q.lvl ? `ACP_LVL_HI : `ACP_LVL_LO;
            `ACP_FB: s_d.rdata = {s_q.alt, s_q.fb};
            `ACP_MODE: s_d.rdata = {8'h00, s_q.mode};
            `ACP_STAT: s_d.rdata = {16'h0000, s_q.vout, 2'h0, s_q.ph};
            default: s_d.rdata = bad ? 32'h0 : {16'h0, s_q.gain[paddr[4:2]*16 +: 16]};
         endcase
      end
      // writes land at the access edge; a refused write changes nothing
      wr = psel && penable && pwrite && !s_q.err;
      if (wr) begin
         case (paddr)
            `ACP_ROUTE: s_d.route = pwdata;
            `ACP_EMB: s_d.emb = pwdata[1:0]; // RULE3
            `ACP_LVL: s_d.lvl = (lv == `ACP_LVL_HI); // RULE4
            `ACP_FB: begin s_d.fb = pwdata[15:0]; s_d.alt = pwdata[31:16]; end
            `ACP_MODE: s_d.mode = pwdata[23:0];
            `ACP_STAT: begin end // read only; the sine phase keeps running
            default: s_d.gain[paddr[4:2]*16 +: 16] = pwdata[15:0]; // RULE12
         endcase
      end
   end

   // single state register
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.route <= `ACP_ROUTE_RST;
         s_q.emb <= 2'h3;
         s_q.lvl <= 1'b1;
         s_q.gain <= {8{`ACP_GAIN_UNITY}};
      end else begin
         s_q <= s_d;
      end
   end

   assign pready = 1'b1; // zero wait state slave
   assign prdata = s_q.rdata;
   assign pslverr = psel && penable && s_q.err;
   assign out_data = s_q.dout;
   assign out_valid = s_q.vout;
   assign out_stb = s_q.stb;
   assign emb_en = s_q.emb;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_strobe;
      smp_stb ##1 out_stb;
   endsequence

   property p_stb_follows;
      smp_stb |-> s_strobe;
   endproperty
   a_stb_follows: assert property (p_stb_follows) else $error("out_stb missed"); // RULE14

   property p_hold;
      !smp_stb |=> $stable(out_data) && $stable(out_valid);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved off boundary"); // RULE14

   property p_lvl_reject;
      psel && penable && pwrite && paddr == `ACP_LVL && lv != `ACP_LVL_HI
         && lv != `ACP_LVL_LO |=> $stable(s_q.lvl);
   endproperty
   a_lvl_reject: assert property (p_lvl_reject) else $error("bad level taken"); // RULE4

   property p_mute;
      smp_stb && s_q.fb[5:4] == 2'h3 |=> !out_valid[2];
   endproperty
   a_mute: assert property (p_mute) else $error("muted output valid"); // RULE13

   property p_emb_off;
      smp_stb && !s_q.emb[1] |=> out_valid[7:4] == 4'h0;
   endproperty
   a_emb_off: assert property (p_emb_off) else $error("group 1 valid while off"); // RULE3

   property p_silence;
      smp_stb && s_q.fb[3:2] == 2'h2 && s_q.mode[5:3] == 3'h0 |=> out_data[47:24] == 24'h0;
   endproperty
   a_silence: assert property (p_silence) else $error("silence not zero"); // RULE2

   property p_pass;
      smp_stb && s_q.mode[2:0] == 3'h0 && s_q.fb[1:0] == 2'h0 && s_q.route[3:0] == 4'h2
         && de_valid[2] && s_q.gain[15:0] == `ACP_GAIN_UNITY
         |=> out_data[23:0] == $past(de_data[71:48]);
   endproperty
   a_pass: assert property (p_pass) else $error("normal pass wrong"); // RULE7

   property p_swap;
      smp_stb && s_q.mode[5:3] == 3'h1 && s_q.gain[31:16] == `ACP_GAIN_UNITY
         |=> out_data[47:24] == $past(co[23:0]);
   endproperty
   a_swap: assert property (p_swap) else $error("swap wrong"); // RULE7

   property p_sine_out;
      smp_stb && s_q.fb[3:2] == 2'h1 |=> out_valid[1] == $past(s_q.emb[0]);
   endproperty
   a_sine_out: assert property (p_sine_out) else $error("sine fallback invalid"); // RULE5

   property p_phase;
      s_q.ph <= `ACP_PH_LAST;
   endproperty
   a_phase: assert property (p_phase) else $error("sine phase out of range"); // RULE2

   // both outputs of a unit pair carry one value in mono and duplicate modes when their gains are equal
   sequence s_pair_equal;
      out_data[23:0] == out_data[47:24];
   endsequence

   property p_mono_same;
      smp_stb && s_q.mode[5:0] == 6'h36 && s_q.gain[15:0] == s_q.gain[31:16]
         |=> s_pair_equal;
   endproperty
   a_mono_same: assert property (p_mono_same) else $error("mono outputs differ"); // RULE10

   property p_dup_same;
      smp_stb && s_q.mode[5:0] == 6'h12 && s_q.gain[15:0] == s_q.gain[31:16]
         |=> s_pair_equal;
   endproperty
   a_dup_same: assert property (p_dup_same) else $error("duplicate outputs differ"); // RULE8

   property p_stb_only;
      out_stb |-> $past(smp_stb);
   endproperty
   a_stb_only: assert property (p_stb_only) else $error("out_stb without strobe"); // RULE14

   property p_emb_on;
      smp_stb && s_q.emb[0] && cv[0] |=> out_valid[0];
   endproperty
   a_emb_on: assert property (p_emb_on) else $error("group 0 valid lost"); // RULE3

   // inverting negative full scale must clip, not wrap back onto itself
   property p_invert_sat;
      smp_stb && s_q.mode[2:0] == 3'h4 && co[23:0] == 24'h800000
         && s_q.gain[15:0] == `ACP_GAIN_UNITY |=> out_data[23:0] == 24'h7fffff;
   endproperty
   a_invert_sat: assert property (p_invert_sat) else $error("invert wrapped"); // RULE15

   property p_route_keep;
      psel && penable && pwrite && paddr == `ACP_ROUTE && s_q.err |=> $stable(s_q.route);
   endproperty
   a_route_keep: assert property (p_route_keep) else $error("refused route taken"); // RULE1

   property p_lvl_take;
      psel && penable && pwrite && paddr == `ACP_LVL && !s_q.err
         |=> s_q.lvl == $past(lv == `ACP_LVL_HI);
   endproperty
   a_lvl_take: assert property (p_lvl_take) else $error("legal level not taken"); // RULE4

   property p_gain_take;
      psel && penable && pwrite && paddr == 8'h20 && !s_q.err
         |=> s_q.gain[15:0] == $past(pwdata[15:0]);
   endproperty
   a_gain_take: assert property (p_gain_take) else $error("gain write lost"); // RULE12

   // a missing routed channel falls back to its second code
   property p_second_code;
      smp_stb && s_q.route[15:12] == 4'h3 && !de_valid[3] && s_q.fb[7:6] == 2'h0
         && s_q.alt[7:6] == 2'h2 && s_q.emb[0] |=> out_valid[3];
   endproperty
   a_second_code: assert property (p_second_code) else $error("second code unused"); // RULE13
endmodule : acp_core
`default_nettype wire

// ==== acp_far_model.sv ====
/*
 far-side model: de-embedder handing one sample per call, embedder capturing the result.
 assumes out_stb follows each smp_stb by one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module acp_far_model (
   input wire logic sys_clk,
   input wire logic [191:0] out_data,
   input wire logic [7:0] out_valid,
   input wire logic out_stb,
   output logic smp_stb,
   output logic [191:0] de_data,
   output logic [7:0] de_valid
);
   logic [191:0] got;
   logic [7:0] got_v;
   initial begin
      smp_stb = 1'b0;
      de_data = 192'h0;
      de_valid = 8'h0;
   end
   // lines are inverted between strobes so a late capture never sees good data
   task automatic send(input logic [191:0] d, input logic [7:0] v);
      @(posedge sys_clk);
      smp_stb <= 1'b1;
      de_data <= d;
      de_valid <= v;
      @(posedge sys_clk);
      smp_stb <= 1'b0;
      de_data <= ~d;
      de_valid <= ~v;
      #1;
      got = out_stb ? out_data : 192'hx;
      got_v = out_valid;
   endtask : send
endmodule : acp_far_model
`default_nettype wire

// ==== audio_crosspoint_channel_processor_test.sv ====
/*
 self-checking bench for acp_core: apb master, table of channel modes, hand tests.
 assumes the far-side model acp_far_model and a 250 MHz clock.
*/
`include "acp_params.svh"
`timescale 1ns/100ps
`default_nettype none
module audio_crosspoint_channel_processor_test;
   import acp_pkg::*;
   typedef struct packed {
      acp_mode_t m;
      logic [15:0] g;
      logic [23:0] l, r, e0, e1;
   } acp_row_t;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, smp_stb, out_stb;
   logic [191:0] de_data, out_data;
   logic [7:0] de_valid, out_valid;
   logic [1:0] emb_en;
   logic signed [23:0] pk0, pk1;
   acp_row_t rows [12];
   int n_fail = 0, checks_done = 0;
   always #2 sys_clk = ~sys_clk;
   acp_core dut (.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .smp_stb, .de_data, .de_valid, .out_data, .out_valid, .out_stb,
      .emb_en);
   acp_far_model p (.sys_clk, .out_data, .out_valid, .out_stb, .smp_stb, .de_data,
      .de_valid);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one apb transfer; waits for pready as long as it takes, the watchdog bounds it
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // one full sine period, keeping the peak of outputs 0 and 1
   task automatic peaks();
      pk0 = 24'sd0;
      pk1 = 24'sd0;
      repeat (48) begin
         p.send(192'h0, 8'hff);
         if ($signed(p.got[23:0]) > pk0) pk0 = p.got[23:0];
         if ($signed(p.got[47:24]) > pk1) pk1 = p.got[47:24];
      end
   endtask : peaks
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   initial begin
      rows[0] = '{normal_mode, 16'h2000, 24'h100000, 24'h040000, 24'h100000, 24'h040000};
      rows[1] = '{swap_mode, 16'h2000, 24'h100000, 24'h040000, 24'h040000, 24'h100000};
      rows[2] = '{left_duplicate_mode, 16'h2000, 24'h100000, 24'h040000, 24'h100000, 24'h100000};
      rows[3] = '{right_duplicate_mode, 16'h2000, 24'h100000, 24'h040000, 24'h040000, 24'h040000};
      rows[4] = '{left_invert_mode, 16'h2000, 24'h100000, 24'h040000, 24'hf00000, 24'h040000};
      rows[5] = '{right_invert_mode, 16'h2000, 24'h100000, 24'h040000, 24'h100000, 24'hfc0000};
      rows[6] = '{mono_mode, 16'h2000, 24'h100000, 24'h040000, 24'h0a0000, 24'h0a0000};
      rows[7] = '{sum_difference_mode, 16'h2000, 24'h100000, 24'h040000, 24'h0a0000, 24'h060000};
      rows[8] = '{left_invert_mode, 16'h2000, 24'h800000, 24'h040000, 24'h7fffff, 24'h040000};
      rows[9] = '{normal_mode, 16'h4000, 24'h600000, 24'h100000, 24'h7fffff, 24'h100000};
      rows[10] = '{sum_difference_mode, 16'h2000, 24'h7fffff, 24'h800000, 24'hffffff, 24'h7fffff};
      rows[11] = '{mono_mode, 16'h1000, 24'h100000, 24'h040000, 24'h050000, 24'h0a0000};
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      chk("emb_rst", 32'h3, emb_en);
      apb(`ACP_ROUTE, 1'b0, 32'h0);
      chk("route_rst", `ACP_ROUTE_RST, rd);
      apb(`ACP_LVL, 1'b0, 32'h0);
      chk("lvl_rst", 32'hffffff4c, rd);
      // modes set on units 0 and 1; gain on unit 0 only
      foreach (rows[i]) begin
         apb(`ACP_MODE, 1'b1, {26'h0, rows[i].m, rows[i].m});
         apb(8'h20, 1'b1, {16'h0, rows[i].g});
         p.send({{6{24'h012345}}, rows[i].r, rows[i].l}, 8'hff);
         chk("unit0", rows[i].e0, p.got[23:0]);
         chk("unit1", rows[i].e1, p.got[47:24]);
         chk("unit2", 32'h012345, p.got[71:48]);
      end
      // a mode write must not move outputs before the next strobe
      apb(`ACP_MODE, 1'b1, 32'h9);
      chk("hold", 32'h050000, out_data[23:0]);
      apb(`ACP_MODE, 1'b1, 32'h0);
      apb(8'h20, 1'b1, 32'h2000);
      apb(`ACP_ROUTE, 1'b1, 32'h76543218);
      apb(`ACP_FB, 1'b1, 32'h4);
      peaks();
      chk("sine_xpt", `ACP_AMP_HI, pk0);
      chk("sine_fb", `ACP_AMP_HI, pk1);
      apb(`ACP_LVL, 1'b1, -32'sd190);
      chk("lvl_bad", 32'h1, er);
      apb(`ACP_LVL, 1'b1, `ACP_LVL_LO);
      chk("lvl_ok", 32'h0, er);
      peaks();
      chk("sine_lo", `ACP_AMP_LO, pk0);
      // out0 silence by route, out1 silence code, out2 mute, out3 second code silence
      apb(`ACP_ROUTE, 1'b1, 32'h76543219);
      apb(`ACP_FB, 1'b1, 32'h00800038);
      p.send({8{24'h123456}}, 8'hf7);
      chk("silence", 32'h0, p.got[23:0] | p.got[47:24]);
      chk("second", 32'h0, p.got[95:72]);
      chk("valid", 32'hfb, p.got_v);
      apb(`ACP_ROUTE, 1'b1, 32'h7654321a);
      chk("route_bad", 32'h1, er);
      apb(`ACP_ROUTE, 1'b0, 32'h0);
      chk("route_keep", 32'h76543219, rd);
      apb(`ACP_FB, 1'b1, 32'h0);
      apb(`ACP_EMB, 1'b1, 32'h1);
      p.send(192'h0, 8'hff);
      chk("emb_en", 32'h1, emb_en);
      chk("emb_valid", 32'hf, p.got_v);
      // channel 2 routed to output 0
      apb(`ACP_ROUTE, 1'b1, 32'h76543212);
      p.send({{5{24'h000000}}, 24'h345678, 48'h0}, 8'hff);
      chk("route2", 32'h345678, p.got[23:0]);
      // 111 strobes so far leave the sine phase at step 15
      apb(`ACP_STAT, 1'b0, 32'h0);
      chk("stat", 32'h00000f0f, rd);
      // a reset in mid-run brings back the defaults
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      chk("emb_rst2", 32'h3, emb_en);
      chk("valid_rst2", 32'h0, out_valid);
      apb(`ACP_ROUTE, 1'b0, 32'h0);
      chk("route_rst2", `ACP_ROUTE_RST, rd);
      test_done();
   end
   // about 350 cycles expected; 25000 allowed
   initial begin
      #100000;
      n_fail++;
      test_done();
   end
endmodule : audio_crosspoint_channel_processor_test
`default_nettype wire
